// ### brg_pkg.sv
// Function
// - All timing derives from the peripheral clock.
// - Timer counts down, stepped by divider or prescaler.
// - Run bit starts and stops the timer.
// - Underflow reloads eight-bit value, emits one pulse.
// - Enabled normal divider mode halts timer, ignores run.
// - Prescaler divides by two to the exponent.
// - Fractional divider scales rate by step over 256.
package brg_pkg;
  localparam int unsigned BRG_RELOAD_W = 8;
  localparam int unsigned BRG_PRE_W = 3;
  localparam int unsigned BRG_STEP_W = 8;
  localparam int unsigned BRG_PRESCALE_CNT_W = 8;
  localparam logic [BRG_RELOAD_W-1:0] BRG_COUNT_RST = 8'h00;
  localparam logic [BRG_STEP_W-1:0] BRG_ACC_RST = 8'h00;

  // ---------------------------------------------------------------
  // Configuration carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic frac_div_enable;
    logic frac_div_mode_select;
    logic [BRG_STEP_W-1:0] frac_step_value;
  } brg_frac_div_control_s;

  typedef struct packed {
    logic run;
    logic [BRG_PRE_W-1:0] prescale_exponent;
  } brg_baud_control_s;
endpackage

// ### brg_baud_rate_generator.sv
`timescale 1ns/1ps
module brg_baud_rate_generator
(
  input wire logic clk,
  input wire logic rst_n,
  input brg_pkg::brg_baud_control_s baud_control,
  input brg_pkg::brg_frac_div_control_s frac_div_control,
  input wire logic [brg_pkg::BRG_RELOAD_W-1:0] baud_reload_value,
  output logic baud_pulse_r,
  output logic frac_div_clock_r,
  output logic timer_running_r,
  output logic [brg_pkg::BRG_RELOAD_W-1:0] count_r
);
  import brg_pkg::*;

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  // The step/256 scaling and the eight-bit reload are fixed by the rate
  // tables of the serial channel, so other widths are refused here.
  if (BRG_STEP_W != 8)
  begin : g_step_width_check
    $error("Fractional step must be eight bits wide.");
  end

  if (BRG_RELOAD_W != 8)
  begin : g_reload_width_check
    $error("Reload value must be eight bits wide.");
  end

  // The prescaler counter must hold every mask bit the exponent can ask for.
  if (BRG_PRESCALE_CNT_W < (1 << BRG_PRE_W) - 1)
  begin : g_prescale_width_check
    $error("Prescaler counter is too narrow for the largest exponent.");
  end

  // ---------------------------------------------------------------
  // Timer state
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BRG_STOPPED = 2'b00,
    BRG_COUNTING = 2'b01,
    BRG_HALTED = 2'b10
  } brg_timer_e;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic brg_normal_mode(input brg_frac_div_control_s fdc);
    return fdc.frac_div_enable && fdc.frac_div_mode_select;
  endfunction

  function automatic logic brg_frac_mode(input brg_frac_div_control_s fdc);
    return fdc.frac_div_enable && !fdc.frac_div_mode_select;
  endfunction

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  logic [BRG_PRESCALE_CNT_W-1:0] pre_cnt_r;
  wire logic [BRG_PRESCALE_CNT_W-1:0] pre_cnt_nxt;
  wire logic [BRG_PRESCALE_CNT_W-1:0] pre_mask;
  wire logic pre_tick;

  // Every mask bit below the exponent is set, so the tick fires when those
  // low counter bits are all ones: once every 2**exponent clocks.
  for (genvar i = 0; i < BRG_PRESCALE_CNT_W; i++)
  begin : g_pre_mask
    assign pre_mask[i] = (i < int'(baud_control.prescale_exponent));
  end

  assign pre_cnt_nxt = pre_cnt_r + 1'b1;
  assign pre_tick = ((pre_cnt_r & pre_mask) == pre_mask);

  // The counter free-runs, so a change of exponent takes effect at once
  // at the cost of one irregular first period.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_r <= '0;
    else
      pre_cnt_r <= pre_cnt_nxt;
  end

  // ---------------------------------------------------------------
  // Fractional divider
  // ---------------------------------------------------------------
  // Accumulating the step on each prescaler tick and taking the carry
  // gives step/256 ticks on average. Normal mode carries on each
  // overflow of an accumulator reloaded from the step value.
  logic [BRG_STEP_W-1:0] acc_r;
  wire logic [BRG_STEP_W-1:0] acc_nxt;
  wire logic [BRG_STEP_W:0] acc_sum;
  wire logic acc_load;
  wire logic fd_carry;
  wire logic fd_tick;
  wire logic fd_en;
  wire logic fd_norm;
  wire logic fd_frac;

  assign fd_en = frac_div_control.frac_div_enable;
  assign fd_norm = brg_normal_mode(frac_div_control);
  assign fd_frac = brg_frac_mode(frac_div_control);
  assign acc_sum = {1'b0, acc_r} + {1'b0, frac_div_control.frac_step_value};
  assign fd_carry = acc_sum[BRG_STEP_W];
  assign acc_load = fd_en && pre_tick;
  assign fd_tick = acc_load && fd_carry;
  assign acc_nxt = (fd_norm && fd_carry) ? frac_div_control.frac_step_value
                                         : acc_sum[BRG_STEP_W-1:0];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      acc_r <= BRG_ACC_RST;
    else if (acc_load)
      acc_r <= acc_nxt;
  end

  // ---------------------------------------------------------------
  // Baud timer
  // ---------------------------------------------------------------
  brg_timer_e timer_state;
  wire logic run_ok;
  wire logic step_src;
  wire logic step_en;
  wire logic underflow;
  wire logic [BRG_RELOAD_W-1:0] count_nxt;

  // Normal divider mode overrides the run bit entirely.
  always_comb
  begin
    timer_state = BRG_STOPPED;
    case ({fd_norm, baud_control.run})
      2'b01: timer_state = BRG_COUNTING;
      2'b10: timer_state = BRG_HALTED;
      2'b11: timer_state = BRG_HALTED;
      default: timer_state = BRG_STOPPED;
    endcase
  end

  assign run_ok = (timer_state == BRG_COUNTING);
  assign step_src = fd_frac ? fd_tick : pre_tick;
  assign step_en = run_ok && step_src;
  assign underflow = step_en && (count_r == '0);
  assign count_nxt = underflow ? baud_reload_value : count_r - 1'b1;

  // The count only moves on a step, so a stopped timer keeps its value
  // and resumes from it when run is set again.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= BRG_COUNT_RST;
    else if (step_en)
      count_r <= count_nxt;
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  // Every output is registered, so each pulse appears one clock after the
  // step that caused it.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      baud_pulse_r <= 1'b0;
    else
      baud_pulse_r <= underflow;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      timer_running_r <= 1'b0;
    else
      timer_running_r <= run_ok;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      frac_div_clock_r <= 1'b0;
    else
      frac_div_clock_r <= fd_tick;
  end
endmodule

// ### brg_sink.sv
`timescale 1ns/1ps
module brg_sink
(
  input wire logic clk,
  input wire logic baud_pulse_r,
  output int pulses
);
  initial pulses = 0;
  always @(posedge clk)
  begin
    if (baud_pulse_r === 1'b1)
      pulses <= pulses + 1;
  end
endmodule

// ### brg_sva.sv
`timescale 1ns/1ps
module brg_chk
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic baud_pulse_r,
  input wire logic frac_div_clock_r,
  input wire logic timer_running_r,
  input brg_pkg::brg_baud_control_s baud_control,
  input brg_pkg::brg_frac_div_control_s frac_div_control,
  input wire logic [7:0] baud_reload_value,
  input wire logic [7:0] count_r
);
  wire logic norm_mode;
  wire logic go;
  assign norm_mode = frac_div_control.frac_div_enable && frac_div_control.frac_div_mode_select;
  assign go = baud_control.run && !norm_mode;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_stopped;
    !go;
  endsequence
  sequence s_normal_mode;
    norm_mode;
  endsequence
  reload_value_a: assert property (baud_pulse_r |-> count_r == $past(baud_reload_value))
    else $error("count is not the reload value at a pulse");
  count_held_a: assert property (s_stopped |=> $stable(count_r) && !baud_pulse_r)
    else $error("stopped timer moved or pulsed");
  run_flag_a: assert property ($past(rst_n) |-> timer_running_r == $past(go))
    else $error("running flag does not follow run");
  count_step_a: assert property (!$stable(count_r) |->
    (count_r == $past(count_r) - 8'h01) || (baud_pulse_r && count_r == $past(baud_reload_value)))
    else $error("count moved other than down or by reload");
  frac_off_a: assert property (!frac_div_control.frac_div_enable |=> !frac_div_clock_r)
    else $error("divider clock while divider disabled");
  normal_halt_a: assert property (s_normal_mode |=> !timer_running_r && !baud_pulse_r)
    else $error("timer ran in normal divider mode");
endmodule
bind brg_baud_rate_generator brg_chk i_chk (.*);

// ### baud_rate_generator_bench.sv
`timescale 1ns/1ps
module baud_rate_generator_bench;
  import brg_pkg::*;
  logic clk = 0, rst_n = 0, baud_pulse_r, frac_div_clock_r, timer_running_r;
  brg_baud_control_s baud_control;
  brg_frac_div_control_s frac_div_control;
  logic [7:0] baud_reload_value, count_r;
  int bad_count = 0, comparisons = 0, pulses, c, p;
  logic [30:0] rows [6] = '{31'h40000403, 31'h58000828, 31'h4C800008, 31'h470005FF,
    31'h4001FF00, 31'h000005FF};
  always #2.5 clk = ~clk;
  brg_baud_rate_generator i_dut (.*);
  brg_sink i_sink (.*);
  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] expected);
    comparisons++;
    if (seen !== expected)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, expected, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("%0d compared, %0d failed", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    foreach (rows[i])
    begin
      rst_n = 0;
      {baud_control, frac_div_control, baud_reload_value} = rows[i][30:9];
      repeat (3) @(negedge clk);
      rst_n = 1;
      repeat (2) for (p = pulses, c = 0; pulses == p && c < 511; c++) @(negedge clk);
      check("period", c[8:0], rows[i][8:0]);
      $display("row %0d done", i);
    end
    // Mid-run reset, then the walk with reload 2 and the prescaler at one.
    baud_control = 4'h8;
    frac_div_control = 10'h000;
    baud_reload_value = 8'h02;
    repeat (4) @(negedge clk);
    rst_n = 0;
    @(negedge clk);
    check("count in reset", count_r, 9'h000);
    check("pulse in reset", baud_pulse_r, 9'h000);
    check("running in reset", timer_running_r, 9'h000);
    check("divider clock in reset", frac_div_clock_r, 9'h000);
    rst_n = 1;
    @(negedge clk);
    check("first reload", count_r, 9'h002);
    check("first pulse", baud_pulse_r, 9'h001);
    check("running", timer_running_r, 9'h001);
    @(negedge clk);
    check("count down", count_r, 9'h001);
    check("pulse low", baud_pulse_r, 9'h000);
    @(negedge clk);
    check("count zero", count_r, 9'h000);
    @(negedge clk);
    check("second reload", count_r, 9'h002);
    check("second pulse", baud_pulse_r, 9'h001);
    $display("reset walk done");
    baud_control = 4'h0;
    @(negedge clk);
    p = pulses;
    repeat (4) @(negedge clk);
    check("held count", count_r, 9'h002);
    check("stopped flag", timer_running_r, 9'h000);
    check("pulses while stopped", 9'(pulses - p), 9'h000);
    $display("stop hold done");
    // Step 128 of 256 gives one divider clock every second cycle.
    frac_div_control = 10'h280;
    baud_control = 4'h8;
    @(negedge clk);
    c = 0;
    repeat (8)
    begin
      @(negedge clk);
      if (frac_div_clock_r === 1'b1)
        c++;
    end
    check("divider clocks", c[8:0], 9'h004);
    $display("fractional clock done");
    report_and_stop;
  end
endmodule
